/* ptpe_defs.svh */
// Constants for the pulse train pattern engine
`ifndef PTPE_DEFS_SVH
`define PTPE_DEFS_SVH

`define PTPE_NCH 16
`define PTPE_NPIN 32
`define PTPE_CHW 4
`define PTPE_SELW 4
`define PTPE_DIVW 17
`define PTPE_LENW 5
`define PTPE_CNTW 16
`define PTPE_PATW 32
`define PTPE_LEN_MIN 5'h01
`define PTPE_DIV_BASE 32'h2

`endif

/* ptpe_pkg.sv */
// Types for the pulse train pattern engine
`include "ptpe_defs.svh"

package ptpe_pkg;

  typedef enum logic {PTPE_MODE_SQUARE, PTPE_MODE_PATTERN} ptpe_mode_e;

  typedef enum logic [1:0] {PTPE_REP_ONCE, PTPE_REP_COUNT, PTPE_REP_ENDLESS} ptpe_rep_e;

  typedef enum logic {PTPE_ST_IDLE, PTPE_ST_RUN} ptpe_state_e;

  typedef struct packed {
    ptpe_mode_e mode;
    ptpe_rep_e rep;
    logic [`PTPE_SELW-1:0] div_sel;
    logic [`PTPE_LENW-1:0] len;
    logic [`PTPE_CNTW-1:0] loop_cnt;
    logic [`PTPE_NCH-1:0] restart_mask;
    logic [`PTPE_PATW-1:0] pattern;
  } ptpe_cfg_s;

  typedef struct packed {
    logic en;
    logic [`PTPE_CHW-1:0] src;
  } ptpe_pin_s;

endpackage

/* ptpe_chan.sv */
// One pulse train channel: divider, pattern shifter and repeat control
`timescale 1ns/1ps
`include "ptpe_defs.svh"

module ptpe_chan (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic en,
  input wire logic start,
  input wire logic stop,
  input ptpe_pkg::ptpe_cfg_s cfg,
  output logic out_q,
  output logic done_q,
  output logic running
);
  import ptpe_pkg::*;

  ptpe_state_e state_q;
  logic [`PTPE_DIVW-1:0] div_q;
  logic [`PTPE_LENW-1:0] idx_q;
  logic [`PTPE_CNTW-1:0] loops_q;
  logic [`PTPE_LENW:0] bits_q;
  logic [`PTPE_LENW-1:0] len_eff;
  logic go;
  logic tick;
  logic last_bit;
  logic last_loop;
  logic finish;
  logic halt;

  // Divide by 2, 4, 8 ... 2^(sel+1)
  function automatic logic [`PTPE_DIVW-1:0] div_term(input logic [`PTPE_SELW-1:0] sel);
    div_term = `PTPE_DIVW'((`PTPE_DIV_BASE << sel) - 32'h1);
  endfunction

  assign len_eff = (cfg.len < `PTPE_LEN_MIN) ? `PTPE_LEN_MIN : cfg.len;
  assign go = en && start;
  assign halt = (state_q == PTPE_ST_RUN) && (!en || stop);
  assign tick = (state_q == PTPE_ST_RUN) && (div_q == div_term(cfg.div_sel));
  assign last_bit = idx_q >= len_eff;
  assign last_loop = (cfg.rep == PTPE_REP_ONCE) ||
    ((cfg.rep == PTPE_REP_COUNT) && ((loops_q + 16'h1) >= cfg.loop_cnt));
  assign finish = tick && (cfg.mode == PTPE_MODE_PATTERN) && last_bit && last_loop;
  assign running = state_q == PTPE_ST_RUN;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= PTPE_ST_IDLE;
    else if (ce)
    begin
      case (state_q)
        PTPE_ST_IDLE:
          if (go)
            state_q <= PTPE_ST_RUN;
        PTPE_ST_RUN:
          if (go)
            state_q <= PTPE_ST_RUN;
          else if (halt || finish)
            state_q <= PTPE_ST_IDLE;
        default:
          state_q <= PTPE_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= '0;
    else if (ce)
    begin
      if (go || !running || tick)
        div_q <= '0;
      else
        div_q <= div_q + `PTPE_DIVW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= 1'b0;
      idx_q <= '0;
      loops_q <= '0;
    end
    else if (ce)
    begin
      if (go)
      begin
        idx_q <= '0;
        loops_q <= '0;
        out_q <= (cfg.mode == PTPE_MODE_SQUARE) ? 1'b1 : cfg.pattern[0];
      end
      else if (halt)
        out_q <= 1'b0;
      else if (tick)
      begin
        if (cfg.mode == PTPE_MODE_SQUARE)
          out_q <= ~out_q;
        else if (!last_bit)
        begin
          idx_q <= idx_q + 5'h1;
          out_q <= cfg.pattern[idx_q + 5'h1];
        end
        else if (last_loop)
        begin
          idx_q <= '0;
          out_q <= 1'b0;
        end
        else
        begin
          idx_q <= '0;
          loops_q <= loops_q + 16'h1;
          out_q <= cfg.pattern[0];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      done_q <= 1'b0;
    else if (ce)
      done_q <= finish && !go;
  end

  // Bits sent since the last start, for checking only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      bits_q <= '0;
    else if (ce)
    begin
      if (go)
        bits_q <= '0;
      else if (tick && cfg.mode == PTPE_MODE_PATTERN)
        bits_q <= bits_q + 6'h1;
    end
  end

  a_start_runs: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && go |=> state_q == PTPE_ST_RUN) else $error("start did not run channel");
  a_single_bits: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(done_q) && $past(cfg.rep) == PTPE_REP_ONCE && $stable(cfg.len)
    |-> bits_q == {1'b0, len_eff} + 6'h1) else $error("single shot bit count wrong");
  a_count_loops: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(done_q) && $past(cfg.rep) == PTPE_REP_COUNT
    |-> ($past(loops_q) + 16'h1) >= $past(cfg.loop_cnt)) else $error("count ended early");
  a_endless_none: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(done_q) |-> $past(cfg.rep) != PTPE_REP_ENDLESS) else $error("endless finished");
  a_done_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    done_q |-> state_q == PTPE_ST_IDLE && !out_q) else $error("finished channel not idle");
  a_div_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && tick && cfg.mode == PTPE_MODE_SQUARE && !go && !halt |=> out_q != $past(out_q))
    else $error("square did not toggle on tick");
  a_div_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && running && !tick && !go && !halt |=> $stable(out_q))
    else $error("output moved between ticks");
endmodule

/* ptpe_top.sv */
// Pulse train pattern engine: sixteen channels, restart links and pin routing
// Function
// - Sixteen channels, each enabled and configured on its own.
// - Square wave or repeating pattern of 2 to 32 bits.
// - Per-channel rate is module clock divided by 2, 4, 8 and upward.
// - Channels start one by one or several together in one cycle.
// - Single shot sends the pattern exactly once.
// - Pattern repeats a set number of times or without end.
// - End of a channel's single shot or loop count can restart selected other channels.
// - Channel outputs routable to general pins as output-only functions.
`timescale 1ns/1ps
`include "ptpe_defs.svh"

module ptpe_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [`PTPE_NCH-1:0] chan_en,
  input wire logic [`PTPE_NCH-1:0] start,
  input wire logic [`PTPE_NCH-1:0] stop,
  input ptpe_pkg::ptpe_cfg_s [`PTPE_NCH-1:0] chan_cfg,
  input ptpe_pkg::ptpe_pin_s [`PTPE_NPIN-1:0] pin_cfg,
  output logic [`PTPE_NCH-1:0] pt_out_q,
  output logic [`PTPE_NCH-1:0] running_q,
  output logic [`PTPE_NCH-1:0] done_q,
  output logic [`PTPE_NPIN-1:0] pin_out_q,
  output logic [`PTPE_NPIN-1:0] pin_oe_q
);
  import ptpe_pkg::*;

  logic [`PTPE_NCH-1:0] ch_out;
  logic [`PTPE_NCH-1:0] ch_done;
  logic [`PTPE_NCH-1:0] ch_run;
  logic [`PTPE_NCH-1:0] restart;
  logic [`PTPE_NCH-1:0] ch_start;

  // Channels named in the mask of any channel that just finished its single shot or count
  function automatic logic [`PTPE_NCH-1:0] restart_vec(
    input logic [`PTPE_NCH-1:0] done,
    input ptpe_cfg_s [`PTPE_NCH-1:0] cfg
  );
    logic [`PTPE_NCH-1:0] acc;
    acc = '0;
    for (int i = 0; i < `PTPE_NCH; i++)
    begin
      if (done[i])
        acc = acc | cfg[i].restart_mask;
    end
    restart_vec = acc;
  endfunction

  // Routed channel level for one pin, low when the pin function is off
  function automatic logic pin_level(
    input ptpe_pin_s pc,
    input logic [`PTPE_NCH-1:0] lvl
  );
    pin_level = pc.en && lvl[pc.src];
  endfunction

  assign restart = restart_vec(ch_done, chan_cfg);
  assign ch_start = start | restart;

  generate
    for (genvar g = 0; g < `PTPE_NCH; g++)
    begin : g_ch
      ptpe_chan u_chan (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .en(chan_en[g]),
        .start(ch_start[g]),
        .stop(stop[g]),
        .cfg(chan_cfg[g]),
        .out_q(ch_out[g]),
        .done_q(ch_done[g]),
        .running(ch_run[g])
      );
    end
  endgenerate

  // Channel levels and status to the outside
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pt_out_q <= '0;
      running_q <= '0;
      done_q <= '0;
    end
    else if (ce)
    begin
      pt_out_q <= ch_out;
      running_q <= ch_run;
      done_q <= ch_done;
    end
  end

  // Output-only pin routing; any pin may carry any channel
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
    end
    else if (ce)
    begin
      for (int p = 0; p < `PTPE_NPIN; p++)
      begin
        pin_out_q[p] <= pin_level(pin_cfg[p], ch_out);
        pin_oe_q[p] <= pin_cfg[p].en;
      end
    end
  end

  // Checks on the assembled engine
  generate
    for (genvar a = 0; a < `PTPE_NCH; a++)
    begin : g_chk
      a_chan_off: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && !chan_en[a] ##1 ce |=> !pt_out_q[a])
        else $error("disabled channel drives output");
      a_restart_path: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && restart[a] && chan_en[a] |=> ch_run[a])
        else $error("restart did not start channel");
      a_done_clears: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && ch_done[a] && !ch_start[a] |=> !running_q[a] && !pt_out_q[a])
        else $error("finished channel still shows running");
    end
  endgenerate

  generate
    for (genvar q = 0; q < `PTPE_NPIN; q++)
    begin : g_pin_chk
      a_pin_route: assert property (@(posedge mclk) disable iff (!rst_n)
        ce |=> pin_out_q[q] == $past(pin_cfg[q].en && ch_out[pin_cfg[q].src])
          && pin_oe_q[q] == $past(pin_cfg[q].en))
        else $error("pin does not follow routed channel");
    end
  endgenerate

  a_group_sync: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && $countones(start & chan_en) > 1 ##1 ce
    |=> (running_q & $past(start & chan_en, 2)) == $past(start & chan_en, 2))
    else $error("group start not synchronous");

  c_group_start: cover property (@(posedge mclk) disable iff (!rst_n)
    ce && $countones(start & chan_en) > 1);
  c_single_done: cover property (@(posedge mclk) disable iff (!rst_n)
    ce && ch_done[0] && chan_cfg[0].rep == PTPE_REP_ONCE);
  c_restart: cover property (@(posedge mclk) disable iff (!rst_n)
    ce && |(restart & chan_en));
  c_endless_run: cover property (@(posedge mclk) disable iff (!rst_n)
    (ch_run[3] && chan_cfg[3].rep == PTPE_REP_ENDLESS) [*8]);
endmodule

/* ptpe_load.sv */
// Pin load model: pulled-down pads fed by the output-only pin functions
`timescale 1ns/1ps
`include "ptpe_defs.svh"

module ptpe_load (
  input wire logic [`PTPE_NPIN-1:0] pin_out_q,
  input wire logic [`PTPE_NPIN-1:0] pin_oe_q,
  output logic [`PTPE_NPIN-1:0] pad
);
  // An undriven pad rests at the pull-down level, never at the last value
  always_comb
  begin
    for (int p = 0; p < `PTPE_NPIN; p++)
      pad[p] = pin_oe_q[p] ? pin_out_q[p] : 1'b0;
  end
endmodule

/* tb_ptpe.sv */
// Self-checking bench for the pulse train pattern engine
`timescale 1ns/1ps
`include "ptpe_defs.svh"

module tb;
  import ptpe_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [`PTPE_NCH-1:0] chan_en = '0;
  logic [`PTPE_NCH-1:0] start = '0;
  logic [`PTPE_NCH-1:0] stop = '0;
  logic ce = 1'b1;
  ptpe_cfg_s [`PTPE_NCH-1:0] chan_cfg = '0;
  ptpe_pin_s [`PTPE_NPIN-1:0] pin_cfg = '0;
  logic [`PTPE_NCH-1:0] pt_out_q, running_q, done_q;
  logic [`PTPE_NPIN-1:0] pin_out_q, pin_oe_q, pad;
  int err_total = 0;
  int check_count = 0;
  int live = 0;
  int kk[16] = '{default: -1};
  int sk[16] = '{default: 0};
  logic [15:0] lfsr = 16'hda28;

  ptpe_top uut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .chan_en(chan_en), .start(start),
    .stop(stop), .chan_cfg(chan_cfg), .pin_cfg(pin_cfg), .pt_out_q(pt_out_q),
    .running_q(running_q), .done_q(done_q), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q));
  ptpe_load load (.pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .pad(pad));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  function automatic int per(int i);
    return 1 << (chan_cfg[i].div_sel + 1);
  endfunction

  function automatic int blen(int i);
    return (chan_cfg[i].len == 0 ? 1 : chan_cfg[i].len) + 1;
  endfunction

  // Cycles of output from first bit to finish; square and endless never finish
  function automatic int total(int i);
    int n;
    n = chan_cfg[i].loop_cnt == 0 ? 1 : chan_cfg[i].loop_cnt;
    if (chan_cfg[i].rep == PTPE_REP_ONCE) n = 1;
    if (chan_cfg[i].mode == PTPE_MODE_SQUARE || chan_cfg[i].rep == PTPE_REP_ENDLESS)
      return 1 << 30;
    return blen(i) * n * per(i);
  endfunction

  // Expected {level, running, done} after the current edge
  function automatic logic [2:0] expv(int i);
    int k, d;
    k = kk[i] - 1;
    d = k / per(i);
    if (kk[i] < 0 || k > total(i)) return 3'h0;
    if (k == total(i)) return 3'h1;
    if (chan_cfg[i].mode == PTPE_MODE_SQUARE) return {d % 2 == 0, 2'h2};
    return {chan_cfg[i].pattern[d % blen(i)], 2'h2};
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Reference model, compared with the design one step after every edge
  always @(posedge mclk)
  begin
    logic [15:0] fin;
    logic [2:0] e[16];
    int s;
    if (!rst_n)
    begin
      live = 0;
      foreach (kk[i]) kk[i] = -1;
    end
    else
    begin
      // A low clock enable freezes the model together with the design
      if (ce)
      begin
        live++;
        for (int j = 0; j < 16; j++)
        begin
          if (kk[j] >= 0) kk[j]++;
          fin[j] = kk[j] == total(j) + 1;
          if (kk[j] > total(j) + 3) kk[j] = -1;
        end
        for (int i = 0; i < 16; i++)
        begin
          if (sk[i] > 0) sk[i]--;
          if (!chan_en[i] || stop[i])
          begin
            if (kk[i] >= 0) sk[i] = 3;
            kk[i] = -1;
          end
          for (int j = 0; j < 16; j++)
            if (chan_en[i] && (start[i] || fin[j] && chan_cfg[j].restart_mask[i])) kk[i] = 0;
        end
      end
      #1;
      for (int i = 0; i < 16; i++)
      begin
        e[i] = expv(i);
        if (live > 2 && sk[i] == 0 && (kk[i] < 0 || kk[i] > 1))
          chk({pt_out_q[i], running_q[i], done_q[i]}, e[i]);
      end
      for (int p = 0; p < 32; p++)
      begin
        s = pin_cfg[p].src;
        if (live > 2 && sk[s] == 0 && (kk[s] < 0 || kk[s] > 1))
          chk({pad[p], pin_oe_q[p]}, {pin_cfg[p].en & e[s][2], pin_cfg[p].en});
      end
    end
  end

  task automatic cfg(int i, ptpe_mode_e m, ptpe_rep_e r, int cnt, logic [15:0] mask);
    chan_cfg[i].mode = m;
    chan_cfg[i].rep = r;
    chan_cfg[i].div_sel = 4'(rnd() % 3);
    chan_cfg[i].len = 5'(rnd());
    chan_cfg[i].loop_cnt = 16'(cnt);
    chan_cfg[i].restart_mask = mask;
    chan_cfg[i].pattern = {rnd(), rnd()};
  endtask

  task automatic go(logic [15:0] m);
    @(negedge mclk);
    start = m;
    @(negedge mclk);
    start = '0;
  endtask

  task automatic wait_idle(logic [15:0] m);
    int n;
    n = 0;
    repeat (2) @(negedge mclk);
    while ((running_q & m) != 0)
    begin
      @(negedge mclk);
      n++;
      if (n > 20000)
      begin
        err_total++;
        end_of_test();
      end
    end
    repeat (4) @(negedge mclk);
    $display("test done for channels %h", m);
  endtask

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    for (int p = 0; p < 32; p++)
      pin_cfg[p] = '{en: p % 4 != 3, src: 4'(p * 3)};
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    chan_en = 16'hff7f;
    // Single shots, the shortest and longest patterns first
    for (int t = 0; t < 6; t++)
    begin
      cfg(t, PTPE_MODE_PATTERN, PTPE_REP_ONCE, 0, '0);
      if (t < 2) chan_cfg[t].len = t ? 5'h1f : 5'h00;
      go(16'(1 << t));
      wait_idle(16'(1 << t));
    end
    cfg(8, PTPE_MODE_PATTERN, PTPE_REP_COUNT, 3, '0);
    cfg(9, PTPE_MODE_PATTERN, PTPE_REP_COUNT, 0, '0);
    go(16'h0300);
    wait_idle(16'h0300);
    // Group start; channel 7 is disabled and must stay idle
    cfg(10, PTPE_MODE_PATTERN, PTPE_REP_COUNT, 2, '0);
    chan_cfg[11] = chan_cfg[10];
    chan_cfg[12] = chan_cfg[10];
    chan_cfg[7] = chan_cfg[10];
    go(16'h1c80);
    wait_idle(16'h1c80);
    cfg(14, PTPE_MODE_PATTERN, PTPE_REP_ONCE, 0, '0);
    cfg(15, PTPE_MODE_PATTERN, PTPE_REP_COUNT, 2, '0);
    cfg(13, PTPE_MODE_PATTERN, PTPE_REP_ONCE, 0, 16'hc000);
    go(16'h2000);
    wait_idle(16'h2000);
    wait_idle(16'hc000);
    cfg(2, PTPE_MODE_SQUARE, PTPE_REP_ONCE, 0, '0);
    cfg(3, PTPE_MODE_PATTERN, PTPE_REP_ENDLESS, 0, '0);
    go(16'h000c);
    // Random clock-enable gaps, then channel 2 stopped and channel 3 disabled
    repeat (200)
    begin
      @(negedge mclk);
      ce = 1'(rnd());
    end
    ce = 1'b1;
    stop = 16'h0004;
    chan_en = 16'hff77;
    wait_idle(16'h000c);
    stop = '0;
    end_of_test();
  end
endmodule
